/* File: bench/pin_timing_formatter_bench.sv */
/* Self-checking bench: Wishbone master, pattern source, reference sums.
   Assumes the pin model on the comparator side and CE held high. */
`timescale 1ns/1ns
module pin_timing_formatter_bench;
  import ptf_pkg::*;
  localparam int PER     = 16;
  localparam int STB_LAT = 5;   // Accepting edge to strobe seen at an edge
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, cyc = 1'b0, we = 1'b0, ack;
  logic        valid = 1'b0, dstart = 1'b0, cstart = 1'b0, run = 1'b0;
  logic [7:0]  adr = 8'h00, offs = 8'h00;
  logic [3:0]  sel = 4'hF, mask = 4'h0, chi, clo, ddat, den;
  logic [31:0] wdat = 32'h0, rdat, pat = 32'h0;
  logic [15:0] stb, fail;
  logic [95:0] vern;
  int          miscompares = 0, n_checks = 0, pc = 0;
  always #20 clk = ~clk;
  // Period starts every PER cycles; compare period shares the drive period
  always @(posedge clk) begin
    pc <= (pc == PER - 1) ? 0 : pc + 1;
    dstart <= run && pc == 0;
    cstart <= run && pc == 0;
  end
  ptf_formatter u_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PATTERN_DATA(pat), .PATTERN_VALID_QUAL(valid),
    .DRIVE_PERIOD_START(dstart), .COMPARE_PERIOD_START(cstart), .DELAY_OFFSET(offs),
    .FAIL_MASK_IN(mask), .COMP_HIGH(chi), .COMP_LOW(clo), .DRIVE_DATA(ddat),
    .DRIVE_EN(den), .EDGE_STROBE(stb), .VERNIER_STEP(vern), .FAIL_OUT(fail));
  ptf_pin_model u_pin (.drv_data(ddat), .drv_en(den), .cmp_high(chi), .cmp_low(clo));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release for one cycle
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) begin
      miscompares++;
      end_sim();
    end
    r = rdat;
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask
  task automatic wave(int c, int e, int p, int dly, int code);
    wr(REG_WADDR, 32'((e << 10) | (c << 8) | p));
    wr(REG_WDATA, 32'((dly << 4) | code));
  endtask
  // Returns at the edge where a drive start is sampled
  task automatic wstart();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (dstart !== 1'b1 && i < 4 * PER);
    if (dstart !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask
  initial begin
    int c, p, o, e, n, r, s, ec, dd, de;
    int dl[4], cl[4], seen[4];
    logic [5:0] vs[4];
    logic [3:0] fq[$];
    void'($urandom(43016));
    dd = 0;
    de = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 16; n++) wave(n / 4, n % 4, 0, 0, 0);
    run <= 1'b1;
    c = $urandom_range(3);
    p = $urandom_range(255, 1);
    o = $urandom_range(255);
    offs <= 8'(o);
    // Drive codes 1..4 then 3..6 with random delay and calibration
    for (r = 0; r < 2; r++) begin
      for (e = 0; e < 4; e++) begin
        dl[e] = $urandom_range(300);
        cl[e] = $urandom_range(127);
        seen[e] = -1;
        wr(REG_CAL_BASE + 8'(4 * (1 + 2 * r + e)), 32'(cl[e]));
        wave(c, e, p, dl[e], 1 + 2 * r + e);
      end
      pat <= 32'(p) << (8 * c);
      valid <= 1'b1;
      wstart();
      valid <= 1'b0;
      for (n = 1; n <= 24; n++) begin
        @(posedge clk);
        for (e = 0; e < 4; e++)
          if (stb[4 * c + e] === 1'b1 && seen[e] < 0) begin
            seen[e] = n;
            vs[e] = vern[(4 * c + e) * 6 +: 6];
          end
      end
      for (e = 0; e < 4; e++) begin
        s = dl[e] + cl[e] + o;
        chk("strobe time", 32'(STB_LAT + s / 64), 32'(seen[e]));
        chk("vernier step", 32'(((s % 64) * 60 + 32) / 64), 32'(vs[e]));
      end
      // Reference drive flops: events in firing order, higher edge wins a tie
      for (n = 0; n < 16; n++)
        for (e = 0; e < 4; e++)
          if ((dl[e] + cl[e] + o) / 64 == n) begin
            s = 1 + 2 * r + e;
            if (s == 1 || s == 5) dd = 0;
            if (s == 2 || s == 4) dd = 1;
            if (s >= 4) de = 1;
            if (s == 3) de = 0;
          end
      chk("drive data", 32'(dd), 32'(ddat[c]));
      chk("drive enable", 32'(de), 32'(den[c]));
      $display("drive run %0d done", r);
    end
    // Same word with the qualifier low: nothing may fire
    s = 0;
    for (n = 0; n < 3 * PER; n++) begin
      @(posedge clk);
      if (stb !== 16'h0) s++;
    end
    chk("strobes while invalid", 32'h0, 32'(s));
    $display("invalid run done");
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl reset", REG_CTRL, CTRL_RESET);
    wr(REG_CTRL, 32'(12) << CTRL_ALIGN_LSB);
    sel <= 4'h3;
    wr(REG_CTRL, 32'h0);
    sel <= 4'hF;
    rdc("ctrl", REG_CTRL, 32'(12) << CTRL_ALIGN_LSB);
    rdc("unmapped", 8'h10, 32'h0);
    offs <= 8'h00;
    wave(c, 0, p, 0, EV_CMP_HI);
    wave(c, 1, p, 64, EV_CMP_MID);
    wave(c, 2, p, 128, EV_WIN_HI);
    wave(c, 3, p, 256, EV_CMP_X);
    // Midband pin: unmasked period, bit-0-masked period, invalid period
    fq = {4'h9, 4'h9, 4'h0};
    ec = $countones(4'h9) + $countones(4'h9 & ~4'h1);
    valid <= 1'b1;
    wstart();
    wstart();
    valid <= 1'b0;
    mask <= 4'h1;
    for (n = 1; n < 40 && fail[4 * c +: 4] === 4'h0; n++) wstart();
    chk("fail latency", 32'(FAIL_FIXED + 12 + 1), 32'(n));
    for (e = 0; e < 3; e++) begin
      chk("fail bits", 32'(fq.pop_front()), 32'(fail[4 * c +: 4]));
      wstart();
    end
    rdc("fail count", REG_CNT_BASE + 8'(4 * c), 32'(ec));
    rdc("fail status", REG_STATUS, 32'(1) << c);
    wr(REG_STATUS, 32'hF);
    wr(REG_CNT_BASE + 8'(4 * c), 32'h0);
    rdc("status clear", REG_STATUS, 32'h0);
    rdc("count clear", REG_CNT_BASE + 8'(4 * c), 32'h0);
    $display("fail run done");
    end_sim();
  end
endmodule

/* File: bench/ptf_formatter_assertions.sv */
/* Port checker for the formatter: bus handshake, event and fail pacing.
   Assumes it is bound to ptf_formatter and sees only its ports. */
`timescale 1ns/1ns
module ptf_chk
  import ptf_pkg::*;
(
  input wire logic                               CLK,
  input wire logic                               RST_N,
  input wire logic                               CE,
  input wire logic                               WB_CYC_I,
  input wire logic                               WB_STB_I,
  input wire logic                               WB_ACK_O,
  input wire logic                               PATTERN_VALID_QUAL,
  input wire logic                               DRIVE_PERIOD_START,
  input wire logic [CHANNELS-1:0]                DRIVE_DATA,
  input wire logic [CHANNELS-1:0]                DRIVE_EN,
  input wire logic [CHANNELS*EVENTS-1:0]         EDGE_STROBE,
  input wire logic [CHANNELS*EVENTS*VERN_W-1:0]  VERNIER_STEP,
  input wire logic [CHANNELS*EVENTS-1:0]         FAIL_OUT
);
  logic       seen_q;
  logic [5:0] st_q;
  logic       vern_ok;
  // Any valid word accepted yet; before that no event may fire
  always_ff @(posedge CLK) begin
    if (!RST_N) seen_q <= 1'b0;
    else if (CE && DRIVE_PERIOD_START && PATTERN_VALID_QUAL) seen_q <= 1'b1;
  end
  // Recent drive starts; fails may only move shortly after one
  always_ff @(posedge CLK) begin
    if (!RST_N) st_q <= 6'h00;
    else st_q <= {st_q[4:0], DRIVE_PERIOD_START};
  end
  // Step index can never reach 60 (largest code maps to 59)
  always_comb begin
    vern_ok = 1'b1;
    for (int i = 0; i < CHANNELS * EVENTS; i++)
      if (VERNIER_STEP[i*VERN_W +: VERN_W] > 6'h3B) vern_ok = 1'b0;
  end
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
  endsequence
  sequence s_ack;
    WB_ACK_O && CE;
  endsequence
  a_ack_latency: assert property (@(posedge CLK) disable iff (!RST_N)
    s_take |=> WB_ACK_O) else $error("ack missing after request");
  a_ack_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    s_ack |=> !WB_ACK_O) else $error("ack longer than one cycle");
  a_ack_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I)) else $error("ack without request");
  a_quiet_invalid: assert property (@(posedge CLK) disable iff (!RST_N)
    !seen_q |-> EDGE_STROBE == '0) else $error("event without valid word");
  a_drive_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    ($changed(DRIVE_DATA) || $changed(DRIVE_EN)) |-> EDGE_STROBE != '0)
    else $error("drive level moved without event");
  a_fail_paced: assert property (@(posedge CLK) disable iff (!RST_N)
    $changed(FAIL_OUT) |-> (st_q != 6'h00 || DRIVE_PERIOD_START))
    else $error("fail output moved off period");
  a_vern_range: assert property (@(posedge CLK) disable iff (!RST_N)
    vern_ok) else $error("vernier step out of range");
  a_reset_clear: assert property (@(posedge CLK)
    (!RST_N && CE) |=> (EDGE_STROBE == '0 && FAIL_OUT == '0 && DRIVE_EN == '0))
    else $error("outputs not cleared by reset");
endmodule
bind ptf_formatter ptf_chk u_chk (.CLK, .RST_N, .CE, .WB_CYC_I, .WB_STB_I, .WB_ACK_O,
  .PATTERN_VALID_QUAL, .DRIVE_PERIOD_START, .DRIVE_DATA, .DRIVE_EN, .EDGE_STROBE,
  .VERNIER_STEP, .FAIL_OUT);

/* File: bench/ptf_pin_model.sv */
/* Far side model: pin drivers, tested pin and dual comparators.
   Assumes comparators follow the pin at once; an undriven pin is midband. */
`timescale 1ns/1ns
module ptf_pin_model
  import ptf_pkg::*;
(
  input  wire logic [CHANNELS-1:0] drv_data,
  input  wire logic [CHANNELS-1:0] drv_en,
  output logic      [CHANNELS-1:0] cmp_high,
  output logic      [CHANNELS-1:0] cmp_low
);
  // Released pin sits at the termination level, between both thresholds
  assign cmp_high = drv_en & drv_data;
  assign cmp_low  = ~drv_en | drv_data;
endmodule

/* File: logic/ptf_formatter.sv */
/*
  Four-channel pin timing formatter: waveform memory, event generators,
  set/reset drive logic, dual comparator compare logic, fail counting and
  fail alignment pipeline, with a classic Wishbone register slave.
  Assumes all pins synchronous to CLK and a pattern source keeping the
  pattern valid qualifier low whenever its data is not meaningful.
*/
`timescale 1ns/1ns
module ptf_formatter
  import ptf_pkg::*;
#(
  parameter int DEPTH = WAVES
) (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic                          CE,
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [7:0]                    WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [31:0]                   WB_DAT_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  input  wire logic [CHANNELS*PAT_W-1:0]     PATTERN_DATA,
  input  wire logic                          PATTERN_VALID_QUAL,
  input  wire logic                          DRIVE_PERIOD_START,
  input  wire logic                          COMPARE_PERIOD_START,
  input  wire logic [OFFS_W-1:0]             DELAY_OFFSET,
  input  wire logic [EVENTS-1:0]             FAIL_MASK_IN,
  input  wire logic [CHANNELS-1:0]           COMP_HIGH,
  input  wire logic [CHANNELS-1:0]           COMP_LOW,
  output logic      [CHANNELS-1:0]           DRIVE_DATA,
  output logic      [CHANNELS-1:0]           DRIVE_EN,
  output logic      [CHANNELS*EVENTS-1:0]    EDGE_STROBE,
  output logic      [CHANNELS*EVENTS*VERN_W-1:0] VERNIER_STEP,
  output logic      [CHANNELS*EVENTS-1:0]    FAIL_OUT
);
  localparam int NE = CHANNELS * EVENTS;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0]        ctrl_q;
  logic [11:0]        waddr_q;
  logic [CHANNELS-1:0] accum_q;
  logic [DELAY_W-1:0] cal_q [16];
  logic [CNT_W-1:0]   fcnt_q [CHANNELS];
  logic [WORD_W-1:0]  mem_q [CHANNELS][DEPTH][EVENTS];
  logic               ack_q;
  logic [31:0]        rdat_q;
  logic               acc_w;
  logic               wr_w;
  logic [CHANNELS-1:0] cnt_clr_w;
  logic [CHANNELS-1:0] acc_set_w;
  logic [CHANNELS-1:0] acc_clr_w;
  logic [1:0]         wa_ch;
  logic [7:0]         wa_ent;
  logic [1:0]         wa_ev;

  assign acc_w  = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr_w   = acc_w && WB_WE_I && (WB_SEL_I == 4'hF) && CE;
  assign wa_ch  = waddr_q[9:8];
  assign wa_ent = waddr_q[7:0];
  assign wa_ev  = waddr_q[11:10];
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else if (CE) begin
      ack_q <= acc_w;
    end
  end

  // Control, pointer and calibration registers; partial writes ignored
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_q  <= CTRL_RESET;
      waddr_q <= 12'h000;
      for (int i = 0; i < 16; i++) begin
        cal_q[i] <= '0;
      end
    end else if (wr_w) begin
      if (WB_ADR_I == REG_CTRL) begin
        ctrl_q <= WB_DAT_I;
      end
      if (WB_ADR_I == REG_WADDR) begin
        waddr_q <= WB_DAT_I[11:0];
      end
      if (WB_ADR_I[7:6] == REG_CAL_BASE[7:6]) begin
        cal_q[WB_ADR_I[5:2]] <= WB_DAT_I[DELAY_W-1:0];
      end
    end
  end

  // Bus write port of waveform memory; lookup uses a separate read path
  always_ff @(posedge CLK) begin
    if (wr_w && WB_ADR_I == REG_WDATA) begin
      mem_q[wa_ch][wa_ent][wa_ev] <= WB_DAT_I[WORD_W-1:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdat_q <= 32'h0000_0000;
    end else if (CE && acc_w) begin
      rdat_q <= 32'h0000_0000;
      if (WB_ADR_I == REG_CTRL) begin
        rdat_q <= ctrl_q;
      end else if (WB_ADR_I == REG_STATUS) begin
        rdat_q <= {28'h0000000, accum_q};
      end else if (WB_ADR_I == REG_WADDR) begin
        rdat_q <= {20'h00000, waddr_q};
      end else if (WB_ADR_I == REG_WDATA) begin
        rdat_q <= {6'h00, mem_q[wa_ch][wa_ent][wa_ev]};
      end else if (WB_ADR_I[7:4] == REG_CNT_BASE[7:4]) begin
        rdat_q <= fcnt_q[WB_ADR_I[3:2]];
      end else if (WB_ADR_I[7:6] == REG_CAL_BASE[7:6]) begin
        rdat_q <= {10'h000, cal_q[WB_ADR_I[5:2]]};
      end
    end
  end

  // Write-one-to-clear strobes for accumulator; any write to a counter clears it
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      acc_clr_w[c] = wr_w && WB_ADR_I == REG_STATUS && WB_DAT_I[c];
      cnt_clr_w[c] = wr_w && WB_ADR_I == {REG_CNT_BASE[7:4], 2'(c), 2'b00};
    end
  end

  // Sticky accumulated fail; a new fail wins over a clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      accum_q <= '0;
    end else if (CE) begin
      accum_q <= (accum_q & ~acc_clr_w) | acc_set_w;
    end
  end

  // ----------------------------------------------------------------
  // Input staging
  // ----------------------------------------------------------------
  logic [1:0]           dps_q;
  logic [1:0]           cps_q;
  logic [OFFS_W-1:0]    offs_q [2];
  logic [1:0]           val_q;
  logic [CHANNELS*PAT_W-1:0] pat_q [2];
  logic                 pat_ok_q;
  logic                 dstart_q;
  logic                 cstart_q;
  logic [WORD_W-1:0]    wave_q [NE];
  logic                 mux_w;
  logic [5:0]           align_w;
  logic [7:0]           rtd_w;

  assign mux_w   = ctrl_q[CTRL_MUX_BIT];
  assign align_w = ctrl_q[CTRL_ALIGN_LSB +: 6];
  assign rtd_w   = ctrl_q[CTRL_RTD_LSB +: 8];

  // Two clock stages on starts, offset and pattern, so all stay aligned
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dps_q     <= 2'b00;
      cps_q     <= 2'b00;
      val_q     <= 2'b00;
      offs_q[0] <= '0;
      offs_q[1] <= '0;
      pat_q[0]  <= '0;
      pat_q[1]  <= '0;
    end else if (CE) begin
      dps_q     <= {dps_q[0], DRIVE_PERIOD_START};
      cps_q     <= {cps_q[0], COMPARE_PERIOD_START};
      offs_q[0] <= DELAY_OFFSET;
      offs_q[1] <= offs_q[0];
      val_q     <= {val_q[0], PATTERN_VALID_QUAL};
      pat_q[0]  <= PATTERN_DATA;
      pat_q[1]  <= pat_q[0];
    end
  end

  // Pattern accepted on drive period start; lookup is the read port
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pat_ok_q <= 1'b0;
      dstart_q <= 1'b0;
      cstart_q <= 1'b0;
      for (int i = 0; i < NE; i++) begin
        wave_q[i] <= '0;
      end
    end else if (CE) begin
      dstart_q <= dps_q[1];
      cstart_q <= cps_q[1];
      if (dps_q[1]) begin
        pat_ok_q <= val_q[1];
        for (int i = 0; i < NE; i++) begin
          wave_q[i] <= mem_q[i/EVENTS][pat_q[1][(i/EVENTS)*PAT_W +: PAT_W]][i%EVENTS];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator state check
  // ----------------------------------------------------------------
  function automatic logic cmp_ok(input logic [CODE_W-1:0] code,
                                  input logic hi, input logic lo);
    logic res;
    res = 1'b1;
    // Low comparator is 1 above the low threshold
    unique case (ptf_evt_t'(code))
      EV_CMP_LO, EV_WIN_LO:   res = !lo;
      EV_CMP_HI, EV_WIN_HI:   res = hi;
      EV_CMP_MID, EV_WIN_MID: res = lo && !hi;
      EV_CMP_VAL, EV_WIN_VAL: res = hi || !lo;
      default:                res = 1'b1;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Event generators, drive, compare and fail logic per channel
  // ----------------------------------------------------------------
  logic [NE-1:0]     fire_w;
  logic [NE-1:0]     efail_w;
  logic [NE-1:0]     wfail_w;
  logic [CODE_W-1:0] ecode_q [NE];
  logic [NE-1:0]     fail_cur_q;
  logic [NE-1:0]     pipe_q [PIPE_LEN];

  genvar gc, ge;
  generate
    for (gc = 0; gc < CHANNELS; gc++) begin : g_ch
      logic hi_w;
      logic lo_w;
      logic [1:0] wopen_q;
      logic [1:0] wbad_q;
      logic [CODE_W-1:0] wcode_q [2];
      logic [EVENTS-1:0] fbits_w;
      logic [2:0] inc_w;

      // Odd channels may take the even neighbour's comparators
      assign hi_w = mux_w ? COMP_HIGH[gc - gc % 2] : COMP_HIGH[gc];
      assign lo_w = mux_w ? COMP_LOW[gc - gc % 2] : COMP_LOW[gc];

      for (ge = 0; ge < EVENTS; ge++) begin : g_ev
        localparam int IX = gc * EVENTS + ge;
        logic [23:0] sum_w;
        logic [19:0] tgt_w;
        logic [19:0] cnt_q;
        logic [19:0] tgt_q;
        logic        armed_q;
        logic        start_w;
        logic [11:0] prod_w;
        logic [CODE_W-1:0] wc_w;

        assign wc_w    = wave_q[IX][CODE_W-1:0];
        assign start_w = ctrl_q[CTRL_SEL_LSB + ge] ? cstart_q : dstart_q;
        // Sum of three terms; top bits count intervals, low six vernier
        assign sum_w = 24'(wave_q[IX][WORD_W-1:CODE_W]) + 24'(cal_q[wc_w])
                     + 24'(offs_q[1]);
        // Compare events slip by the round-trip pipeline delay
        assign tgt_w = 20'(sum_w[23:VERN_W])
                     + ((wc_w >= CODE_W'(EV_CMP_LO)) ? 20'(rtd_w) : 20'h00000);
        assign prod_w = 12'(sum_w[VERN_W-1:0]) * 12'(VERN_STEPS) + 12'h020;
        assign fire_w[IX] = armed_q && cnt_q == tgt_q;

        // Counter from period start; only valid patterns arm it
        always_ff @(posedge CLK) begin
          if (!RST_N) begin
            armed_q     <= 1'b0;
            cnt_q       <= '0;
            tgt_q       <= '0;
            ecode_q[IX] <= '0;
            VERNIER_STEP[IX*VERN_W +: VERN_W] <= '0;
          end else if (CE) begin
            if (start_w) begin
              armed_q     <= pat_ok_q && wc_w != CODE_W'(EV_NONE);
              cnt_q       <= '0;
              tgt_q       <= tgt_w;
              ecode_q[IX] <= wc_w;
              VERNIER_STEP[IX*VERN_W +: VERN_W] <= prod_w[11:6];
            end else if (armed_q) begin
              if (cnt_q == tgt_q) begin
                armed_q <= 1'b0;
              end else begin
                cnt_q <= cnt_q + 20'h00001;
              end
            end
          end
        end

        // Single edge compares fail on mismatch
        assign efail_w[IX] = fire_w[IX] && ecode_q[IX] >= CODE_W'(EV_CMP_LO)
                           && ecode_q[IX] <= CODE_W'(EV_CMP_VAL)
                           && ecode_q[IX] != CODE_W'(EV_CMP_X)
                           && !cmp_ok(ecode_q[IX], hi_w, lo_w);
        // Window fail reported only on the closing edge
        if (ge % 2 == 1) begin : g_wc
          assign wfail_w[IX] = fire_w[IX] && wopen_q[ge/2]
                             && (wbad_q[ge/2] || !cmp_ok(wcode_q[ge/2], hi_w, lo_w));
        end else begin : g_wo
          assign wfail_w[IX] = 1'b0;
        end
        assign fbits_w[ge] = efail_w[IX] || wfail_w[IX];
      end

      // Window state for edge pairs 0/1 and 2/3
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          wopen_q    <= 2'b00;
          wbad_q     <= 2'b00;
          wcode_q[0] <= '0;
          wcode_q[1] <= '0;
        end else if (CE) begin
          for (int p = 0; p < 2; p++) begin
            if (wopen_q[p] && !cmp_ok(wcode_q[p], hi_w, lo_w)) begin
              wbad_q[p] <= 1'b1;
            end
            if (fire_w[gc*EVENTS+2*p+1]) begin
              wopen_q[p] <= 1'b0;
            end
            if (fire_w[gc*EVENTS+2*p] && ecode_q[gc*EVENTS+2*p] >= CODE_W'(EV_WIN_LO)) begin
              wopen_q[p] <= 1'b1;
              wbad_q[p]  <= 1'b0;
              wcode_q[p] <= ecode_q[gc*EVENTS+2*p];
            end
          end
        end
      end

      // Set/reset drive flops; in multiplex mode even pins add odd events
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          DRIVE_DATA[gc] <= 1'b0;
          DRIVE_EN[gc]   <= 1'b0;
        end else if (CE) begin
          for (int s = 0; s < 2 * EVENTS; s++) begin
            if ((s < EVENTS || (mux_w && gc % 2 == 0)) && gc * EVENTS + s < NE
                && fire_w[(gc*EVENTS+s)%NE]) begin
              unique case (ptf_evt_t'(ecode_q[(gc*EVENTS+s)%NE]))
                EV_DRV_LO: DRIVE_DATA[gc] <= 1'b0;
                EV_DRV_HI: DRIVE_DATA[gc] <= 1'b1;
                EV_OFF:    DRIVE_EN[gc]   <= 1'b0;
                EV_UP: begin
                  DRIVE_EN[gc]   <= 1'b1;
                  DRIVE_DATA[gc] <= 1'b1;
                end
                EV_DOWN: begin
                  DRIVE_EN[gc]   <= 1'b1;
                  DRIVE_DATA[gc] <= 1'b0;
                end
                EV_PRIOR:  DRIVE_EN[gc]   <= 1'b1;
                default:   DRIVE_EN[gc]   <= DRIVE_EN[gc];
              endcase
            end
          end
        end
      end

      // Unmasked fails count and set the accumulator; output keeps all
      assign inc_w = 3'(fbits_w[0] & !FAIL_MASK_IN[0]) + 3'(fbits_w[1] & !FAIL_MASK_IN[1])
                   + 3'(fbits_w[2] & !FAIL_MASK_IN[2]) + 3'(fbits_w[3] & !FAIL_MASK_IN[3]);
      assign acc_set_w[gc] = inc_w != 3'b000;

      // Counter clear by write, but a same-cycle fail still counts
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          fcnt_q[gc] <= '0;
        end else if (CE) begin
          fcnt_q[gc] <= (cnt_clr_w[gc] ? '0 : fcnt_q[gc]) + CNT_W'(inc_w);
        end
      end

      // Collect fails of the current period; new fails survive the push
      always_ff @(posedge CLK) begin
        if (!RST_N) begin
          fail_cur_q[gc*EVENTS +: EVENTS] <= '0;
        end else if (CE) begin
          fail_cur_q[gc*EVENTS +: EVENTS] <= (dstart_q ? '0 : fail_cur_q[gc*EVENTS +: EVENTS])
                                           | fbits_w;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Fail alignment pipeline, advanced once per drive period
  // ----------------------------------------------------------------
  // Depth above the maximum is clamped; software owns the lower bound
  logic [5:0] tap_w;
  assign tap_w = 6'(FAIL_FIXED) - 6'd2
               + ((align_w > 6'(ALIGN_MAX)) ? 6'(ALIGN_MAX) : align_w);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < PIPE_LEN; i++) begin
        pipe_q[i] <= '0;
      end
      FAIL_OUT    <= '0;
      EDGE_STROBE <= '0;
    end else if (CE) begin
      EDGE_STROBE <= fire_w;
      if (dstart_q) begin
        pipe_q[0] <= fail_cur_q;
        for (int i = 1; i < PIPE_LEN; i++) begin
          pipe_q[i] <= pipe_q[i-1];
        end
        FAIL_OUT <= pipe_q[tap_w];
      end
    end
  end
endmodule

/* File: logic/ptf_pkg.sv */
/*
  Constants, register map and event codes for the pin timing formatter.
  Assumes a single master clock domain and a classic Wishbone register bus.
*/
package ptf_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int CHANNELS    = 4;
  localparam int EVENTS      = 4;
  localparam int WAVES       = 256;
  localparam int PAT_W       = 8;
  localparam int DELAY_W     = 22;
  localparam int CODE_W      = 4;
  localparam int WORD_W      = 26;
  localparam int OFFS_W      = 8;
  localparam int VERN_W      = 6;
  localparam int VERN_STEPS  = 60;
  localparam int CNT_W       = 32;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int INTERVAL_PS = 2500;
  localparam int RES_FS      = 39060;
  localparam int SYNC_STAGES = 2;
  localparam int FAIL_FIXED  = 8;
  localparam int ALIGN_MAX   = 30;
  localparam int PIPE_LEN    = FAIL_FIXED + ALIGN_MAX;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_WADDR    = 8'h08;
  localparam logic [7:0] REG_WDATA    = 8'h0C;
  localparam logic [7:0] REG_CNT_BASE = 8'h20;
  localparam logic [7:0] REG_CAL_BASE = 8'h40;
  localparam int CTRL_MUX_BIT   = 0;
  localparam int CTRL_SEL_LSB   = 8;
  localparam int CTRL_ALIGN_LSB = 16;
  localparam int CTRL_RTD_LSB   = 24;
  localparam logic [31:0] CTRL_RESET = 32'h001E_0000;
  // ----------------------------------------------------------------
  // Event codes
  // ----------------------------------------------------------------
  typedef enum logic [CODE_W-1:0] {
    EV_NONE, EV_DRV_LO, EV_DRV_HI, EV_OFF, EV_UP, EV_DOWN, EV_PRIOR,
    EV_CMP_LO, EV_CMP_HI, EV_CMP_X, EV_CMP_MID, EV_CMP_VAL,
    EV_WIN_LO, EV_WIN_HI, EV_WIN_MID, EV_WIN_VAL
  } ptf_evt_t;
endpackage
